// ===== prog_end_ctrl.sv
// program end sequencing and manipulated value selection
// Contract
// R1 - finish: pv main, sp/finish alternate half-second
// R2 - finished signal routable, shown in status
// R3 - pattern off to on: aux1 gets finished
// R4 - pattern to off: alarm1 default function
// R5 - start to reset clears finished state
// R6 - event-assigned start: only event clears
// R7 - reset to running forces run
// R8 - reset before soak expiry forces stop
// R9 - stop pattern: soak done stops, flags
// R10 - start while running keeps run
// R11 - stopped: soak counts inside band only
// R12 - back to run resumes soak count
// R13 - clamp calculated mv to limits
// R14 - manual limit enable clamps manual mv
// R15 - one limit pair for heat/cool
// R16 - stop mv sign picks heat/cool side
// R17 - stop mv used only when enabled
// R18 - stop mv zero default, range checked
// R19 - error mv while input error, ranged
// R20 - priority manual, stop, then error
// R21 - special values bypass limits
// R22 - soak advances only within band
// R23 - off: no program; continue_after_finish stays run
// R24 - start by key, event or host
// R25 - finished held until start reset
`timescale 1ns/1ps
module prog_end_ctrl #(
   parameter int soak_unit_cycles = prog_end_pkg::sec_cycles * 60,
   parameter int blink_cycles = prog_end_pkg::blink_cycles
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic [1:0] avs_response,
   input wire logic start_event_pin,
   input wire logic signed [15:0] process_value,
   input wire logic signed [15:0] set_point,
   input wire logic input_error,
   input wire logic signed [11:0] calc_mv,
   output logic signed [11:0] manipulated_value,
   output logic heat_out_sel,
   output logic cool_out_sel,
   output logic run_state,
   output logic program_finished,
   output logic show_finish,
   output logic [3:0] aux1_assign,
   output logic [3:0] alarm1_assign
);
   // refuse counts the counters cannot serve
   initial begin
      if (soak_unit_cycles < 1) begin
         $error("soak unit needs at least one cycle");
      end
      if (blink_cycles < 1) begin
         $error("blink half period needs at least one cycle");
      end
   end

   typedef struct packed {
      logic [1:0] pattern;
      logic start_on_event;
      logic heatcool;
      logic heater_alarm_fitted;
      logic stop_err_en;
      logic manual_lim_en;
      logic manual_mode;
      logic key_start;
      logic run;
      logic running;
      logic finished;
      logic [15:0] soak_set;
      logic [15:0] wait_band;
      logic [15:0] soak_acc;
      logic [31:0] unit_cnt;
      logic [31:0] blink_cnt;
      logic blink;
      logic signed [11:0] lim_hi;
      logic signed [11:0] lim_lo;
      logic signed [11:0] mv_stop;
      logic signed [11:0] mv_err;
      logic signed [11:0] mv_manual;
      logic signed [11:0] mv;
      logic [3:0] aux1;
      logic [3:0] alarm1;
      logic [2:0] ev_sync;
      logic ev_level;
      logic ack;
      logic [31:0] rdata;
      logic [1:0] resp;
   } state_t;

   state_t st_ff;
   state_t nxt_st;
   logic [1:0] rst_sync_ff;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_ff[1];

   function automatic logic signed [11:0] clamp(input logic signed [11:0] v,
                                                input logic signed [11:0] lo,
                                                input logic signed [11:0] hi);
      logic signed [11:0] r;
      r = v;
      if (v > hi) begin
         r = hi;
      end
      if (v < lo) begin
         r = lo;
      end
      return r;
   endfunction : clamp

   // range limit for written limit, stop, error and manual values
   function automatic logic signed [11:0] range_fix(input logic signed [11:0] v, input logic hc);
      logic signed [11:0] lo;
      lo = hc ? prog_end_pkg::mv_hc_min : prog_end_pkg::mv_std_min;
      return clamp(v, lo, prog_end_pkg::mv_max);
   endfunction : range_fix

   logic start_req;
   logic start_now;
   logic rise;
   logic fall;
   logic signed [16:0] diff;
   logic signed [16:0] band_s;
   logic wr_ok;
   logic in_band;
   logic acc;
   logic wr;
   logic rd;

   always_comb begin
      nxt_st = st_ff;

      // one wait state: first cycle arms ack, write lands when waitrequest is low
      acc = (avs_read || avs_write) && !st_ff.ack;
      wr = avs_write && st_ff.ack;
      rd = acc && avs_read;
      nxt_st.ack = acc;
      nxt_st.resp = 2'h0;
      wr_ok = (avs_address == prog_end_pkg::reg_ctrl) ||
              (avs_address == prog_end_pkg::reg_soak) ||
              (avs_address == prog_end_pkg::reg_band) ||
              (avs_address == prog_end_pkg::reg_lim) ||
              (avs_address == prog_end_pkg::reg_mvsel) ||
              (avs_address == prog_end_pkg::reg_manual) ||
              (avs_address == prog_end_pkg::reg_assign);
      if (acc && avs_write && !wr_ok) begin
         nxt_st.resp = 2'h2;
      end

      // event input synchroniser
      nxt_st.ev_sync = {st_ff.ev_sync[1:0], start_event_pin};
      if (st_ff.ev_sync[2] == st_ff.ev_sync[1]) begin
         nxt_st.ev_level = st_ff.ev_sync[1];
      end

      // start source selection
      start_req = st_ff.start_on_event ? st_ff.ev_level : st_ff.key_start; // [R6] [R24]
      start_now = start_req && (st_ff.pattern != 2'(prog_end_pkg::pat_off)); // [R23]
      rise = start_now && !st_ff.running;
      fall = !start_now && st_ff.running;
      nxt_st.running = start_now;
      if (rise) begin
         nxt_st.run = 1'b1; // [R7] [R10]
         nxt_st.soak_acc = 16'h0000;
         nxt_st.unit_cnt = 32'h0;
         nxt_st.finished = 1'b0;
      end
      if (fall) begin
         if (!st_ff.finished) begin
            nxt_st.run = 1'b0; // [R8]
         end
         nxt_st.finished = 1'b0; // [R5] [R25]
      end

      // soak counting, independent of run state
      diff = 17'(process_value) - 17'(set_point);
      band_s = signed'({1'b0, st_ff.wait_band});
      in_band = (st_ff.wait_band == 16'h0000) ||
                ((diff <= band_s) && (-diff <= band_s)); // [R22]
      if (st_ff.running && !st_ff.finished && in_band) begin // [R11] [R12]
         if (st_ff.unit_cnt >= 32'(soak_unit_cycles - 1)) begin
            nxt_st.unit_cnt = 32'h0;
            nxt_st.soak_acc = st_ff.soak_acc + 16'h0001;
         end else begin
            nxt_st.unit_cnt = st_ff.unit_cnt + 32'h1;
         end
      end
      if (st_ff.running && !st_ff.finished && !fall && st_ff.soak_acc >= st_ff.soak_set) begin
         nxt_st.finished = 1'b1; // [R25]
         if (st_ff.pattern == 2'(prog_end_pkg::pat_stop)) begin
            nxt_st.run = 1'b0; // [R9] [R23]
         end
      end

      // finish blink
      if (st_ff.finished) begin
         if (st_ff.blink_cnt >= 32'(blink_cycles - 1)) begin
            nxt_st.blink_cnt = 32'h0;
            nxt_st.blink = !st_ff.blink; // [R1]
         end else begin
            nxt_st.blink_cnt = st_ff.blink_cnt + 32'h1;
         end
      end else begin
         nxt_st.blink_cnt = 32'h0;
         nxt_st.blink = 1'b0;
      end

      // mv selection
      if (st_ff.manual_mode) begin
         if (st_ff.manual_lim_en) begin
            nxt_st.mv = clamp(st_ff.mv_manual, st_ff.lim_lo, st_ff.lim_hi); // [R14] [R20]
         end else begin
            nxt_st.mv = st_ff.mv_manual; // [R20] [R21]
         end
      end else if (!st_ff.run && st_ff.stop_err_en) begin
         nxt_st.mv = st_ff.mv_stop; // [R17] [R20] [R21]
      end else if (!st_ff.run) begin
         nxt_st.mv = prog_end_pkg::mv_stop_rst; // [R18]
      end else if (input_error) begin
         nxt_st.mv = st_ff.mv_err; // [R19] [R20] [R21]
      end else begin
         nxt_st.mv = clamp(calc_mv, st_ff.lim_lo, st_ff.lim_hi); // [R13] [R15]
      end

      // register writes
      if (wr) begin
         unique case (avs_address)
            prog_end_pkg::reg_ctrl: begin
               if (avs_writedata[1:0] != st_ff.pattern && avs_writedata[1:0] != 2'h3) begin
                  if (st_ff.pattern == 2'(prog_end_pkg::pat_off)) begin
                     nxt_st.aux1 = prog_end_pkg::asg_program_finished; // [R3]
                  end
                  if (avs_writedata[1:0] == 2'(prog_end_pkg::pat_off)) begin
                     nxt_st.alarm1 = avs_writedata[4] ? prog_end_pkg::asg_heater_alarm_function
                                                      : prog_end_pkg::asg_first_alarm_function; // [R4]
                  end
                  nxt_st.pattern = avs_writedata[1:0];
               end
               nxt_st.start_on_event = avs_writedata[2];
               nxt_st.heatcool = avs_writedata[3];
               nxt_st.heater_alarm_fitted = avs_writedata[4];
               nxt_st.stop_err_en = avs_writedata[5];
               nxt_st.manual_lim_en = avs_writedata[6];
               nxt_st.manual_mode = avs_writedata[7];
               if (!st_ff.start_on_event) begin
                  nxt_st.key_start = avs_writedata[8]; // [R6]
               end
               if (avs_writedata[9]) begin
                  nxt_st.run = avs_writedata[10];
               end
            end
            prog_end_pkg::reg_soak: nxt_st.soak_set = avs_writedata[15:0];
            prog_end_pkg::reg_band: nxt_st.wait_band = avs_writedata[15:0];
            prog_end_pkg::reg_lim: begin
               nxt_st.lim_lo = range_fix(avs_writedata[11:0], st_ff.heatcool);
               nxt_st.lim_hi = range_fix(avs_writedata[27:16], st_ff.heatcool);
            end
            prog_end_pkg::reg_mvsel: begin
               nxt_st.mv_stop = range_fix(avs_writedata[11:0], st_ff.heatcool); // [R18]
               nxt_st.mv_err = range_fix(avs_writedata[27:16], st_ff.heatcool); // [R19]
            end
            prog_end_pkg::reg_manual: nxt_st.mv_manual = range_fix(avs_writedata[11:0], st_ff.heatcool);
            prog_end_pkg::reg_assign: begin
               nxt_st.aux1 = avs_writedata[3:0]; // [R2]
               nxt_st.alarm1 = avs_writedata[7:4];
            end
            default: ;
         endcase
      end

      // register reads, data stands while waitrequest is low
      nxt_st.rdata = 32'h0;
      if (rd) begin
         unique case (avs_address)
            prog_end_pkg::reg_ctrl: begin
               nxt_st.rdata[1:0] = st_ff.pattern;
               nxt_st.rdata[2] = st_ff.start_on_event;
               nxt_st.rdata[3] = st_ff.heatcool;
               nxt_st.rdata[4] = st_ff.heater_alarm_fitted;
               nxt_st.rdata[5] = st_ff.stop_err_en;
               nxt_st.rdata[6] = st_ff.manual_lim_en;
               nxt_st.rdata[7] = st_ff.manual_mode;
               nxt_st.rdata[8] = start_req;
               nxt_st.rdata[10] = st_ff.run;
            end
            prog_end_pkg::reg_soak: nxt_st.rdata = {16'h0, st_ff.soak_set};
            prog_end_pkg::reg_band: nxt_st.rdata = {16'h0, st_ff.wait_band};
            prog_end_pkg::reg_lim: begin
               nxt_st.rdata[11:0] = st_ff.lim_lo;
               nxt_st.rdata[27:16] = st_ff.lim_hi;
            end
            prog_end_pkg::reg_mvsel: begin
               nxt_st.rdata[11:0] = st_ff.mv_stop;
               nxt_st.rdata[27:16] = st_ff.mv_err;
            end
            prog_end_pkg::reg_manual: nxt_st.rdata = {20'h0, st_ff.mv_manual};
            prog_end_pkg::reg_status: begin
               nxt_st.rdata[0] = st_ff.finished; // [R2]
               nxt_st.rdata[1] = st_ff.run;
               nxt_st.rdata[2] = st_ff.running;
               nxt_st.rdata[3] = st_ff.blink;
               nxt_st.rdata[31:16] = st_ff.soak_acc;
            end
            prog_end_pkg::reg_assign: nxt_st.rdata = {24'h0, st_ff.alarm1, st_ff.aux1};
            prog_end_pkg::reg_mvout: nxt_st.rdata = {20'h0, st_ff.mv};
            default: nxt_st.resp = 2'h2;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff.pattern <= 2'h0;
         st_ff.start_on_event <= 1'b0;
         st_ff.heatcool <= 1'b0;
         st_ff.heater_alarm_fitted <= 1'b0;
         st_ff.stop_err_en <= 1'b0;
         st_ff.manual_lim_en <= 1'b0;
         st_ff.manual_mode <= 1'b0;
         st_ff.key_start <= 1'b0;
         st_ff.run <= 1'b0;
         st_ff.running <= 1'b0;
         st_ff.finished <= 1'b0;
         st_ff.soak_acc <= 16'h0000;
         st_ff.unit_cnt <= 32'h0;
         st_ff.blink_cnt <= 32'h0;
         st_ff.blink <= 1'b0;
         st_ff.mv_manual <= 12'sh0;
         st_ff.mv <= 12'sh0;
         st_ff.ev_sync <= 3'h0;
         st_ff.ev_level <= 1'b0;
         st_ff.ack <= 1'b0;
         st_ff.rdata <= 32'h0;
         st_ff.resp <= 2'h0;
         st_ff.soak_set <= prog_end_pkg::soak_rst;
         st_ff.wait_band <= prog_end_pkg::band_rst;
         st_ff.lim_hi <= prog_end_pkg::lim_hi_rst;
         st_ff.lim_lo <= prog_end_pkg::lim_lo_rst;
         st_ff.mv_stop <= prog_end_pkg::mv_stop_rst;
         st_ff.mv_err <= prog_end_pkg::mv_err_rst;
         st_ff.aux1 <= prog_end_pkg::asg_aux1_rst;
         st_ff.alarm1 <= prog_end_pkg::asg_first_alarm_function;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && !st_ff.ack;
   assign avs_readdata = st_ff.rdata;
   assign avs_response = st_ff.resp;
   assign manipulated_value = st_ff.mv;
   assign heat_out_sel = !st_ff.heatcool || !st_ff.mv[11]; // [R16]
   assign cool_out_sel = st_ff.heatcool && st_ff.mv[11]; // [R16]
   assign run_state = st_ff.run;
   assign program_finished = st_ff.finished; // [R25]
   assign show_finish = st_ff.blink; // [R1]
   assign aux1_assign = st_ff.aux1;
   assign alarm1_assign = st_ff.alarm1;
endmodule : prog_end_ctrl

// ===== prog_end_pkg.sv
// constants and types for program end and output selection
package prog_end_pkg;
   localparam int clk_hz = 125_000_000;
   localparam int blink_ms = 500;
   localparam int blink_cycles = (clk_hz / 1000) * blink_ms;
   localparam int sec_ms = 1000;
   localparam int sec_cycles = (clk_hz / 1000) * sec_ms;
   // avalon register offsets (byte addresses)
   localparam logic [5:0] reg_ctrl = 6'h00;
   localparam logic [5:0] reg_soak = 6'h04;
   localparam logic [5:0] reg_band = 6'h08;
   localparam logic [5:0] reg_lim = 6'h0c;
   localparam logic [5:0] reg_mvsel = 6'h10;
   localparam logic [5:0] reg_manual = 6'h14;
   localparam logic [5:0] reg_status = 6'h18;
   localparam logic [5:0] reg_assign = 6'h1c;
   localparam logic [5:0] reg_mvout = 6'h20;
   // mv values in 0.1 percent, signed 12 bit
   localparam logic signed [11:0] mv_std_min = -12'sd50;
   localparam logic signed [11:0] mv_max = 12'sd1050;
   localparam logic signed [11:0] mv_hc_min = -12'sd1050;
   localparam logic signed [11:0] mv_stop_rst = 12'sd0;
   localparam logic signed [11:0] mv_err_rst = 12'sd0;
   localparam logic signed [11:0] lim_hi_rst = 12'sd1050;
   localparam logic signed [11:0] lim_lo_rst = -12'sd50;
   localparam logic [15:0] soak_rst = 16'h0001;
   localparam logic [15:0] band_rst = 16'h0000;
   // output assignment codes
   localparam logic [3:0] asg_first_alarm_function = 4'h1;
   localparam logic [3:0] asg_heater_alarm_function = 4'h2;
   localparam logic [3:0] asg_program_finished = 4'h3;
   localparam logic [3:0] asg_aux1_rst = 4'h0;
   typedef enum logic [1:0] {
      pat_off = 2'h0,
      pat_stop = 2'h1,
      pat_continue_after_finish = 2'h2
   } pattern_t;
endpackage : prog_end_pkg

// ===== prog_end_monitor.sv
// port checker for program end and mv selection
`timescale 1ns/1ps
module prog_end_monitor #(
   parameter int blink_cycles = 4
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [1:0] avs_response,
   input wire logic signed [11:0] manipulated_value,
   input wire logic heat_out_sel,
   input wire logic cool_out_sel,
   input wire logic program_finished,
   input wire logic show_finish
);
   logic req;
   logic [15:0] hold_ff;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   assign req = avs_read | avs_write;
   // cycles the finish indication has stood unchanged
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         hold_ff <= 16'h0;
      else if (program_finished && $stable(show_finish))
         hold_ff <= hold_ff + 16'h1;
      else
         hold_ff <= 16'h0;
   end
   req_wait_a: assert property ($rose(req) |-> avs_waitrequest)
      else $error("request not held off in its first cycle");
   wait_bound_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("more than one wait state");
   bad_addr_a: assert property (req && !avs_waitrequest && avs_address > 6'h20 |-> avs_response == 2'h2)
      else $error("unmapped access not flagged");
   good_addr_a: assert property (req && !avs_waitrequest && avs_address <= 6'h20 && avs_address[1:0] == 2'h0
      |-> avs_response == 2'h0) else $error("mapped access flagged");
   rdata_idle_a: assert property (!avs_read [*2] |-> avs_readdata == 32'h0)
      else $error("read data left standing");
   side_excl_a: assert property (!(heat_out_sel && cool_out_sel))
      else $error("heat and cool both selected");
   mv_range_a: assert property (manipulated_value >= prog_end_pkg::mv_hc_min &&
      manipulated_value <= prog_end_pkg::mv_max) else $error("mv out of range");
   blink_gap_a: assert property (hold_ff <= 16'(blink_cycles))
      else $error("finish indication not alternating");
   finish_blank_a: assert property (!program_finished [*2] |-> !show_finish)
      else $error("finish indication without finish");
   cover property (avs_write && !avs_waitrequest);
   cover property (avs_read && !avs_waitrequest);
   cover property ($rose(program_finished));
   cover property (program_finished && $rose(show_finish));
endmodule : prog_end_monitor
bind prog_end_ctrl prog_end_monitor #(.blink_cycles(blink_cycles)) i_prog_end_monitor (.*);

// ===== op_model.sv
// event input, input error, calculated mv and plant value model
`timescale 1ns/1ps
module op_model (
   input wire logic clk,
   input wire logic want_ev,
   input wire logic signed [15:0] want_pv,
   input wire logic want_err,
   input wire logic signed [11:0] want_calc,
   output logic start_event_pin,
   output logic signed [15:0] process_value,
   output logic signed [15:0] set_point,
   output logic input_error,
   output logic signed [11:0] calc_mv
);
   assign set_point = 16'sh0;
   always @(posedge clk) begin
      start_event_pin <= want_ev;
      process_value <= want_pv;
      input_error <= want_err;
      calc_mv <= want_calc;
   end
endmodule : op_model

// ===== tb_top.sv
// testbench for program end and mv selection
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [1:0] avs_response;
   logic start_event_pin;
   logic signed [15:0] process_value;
   logic signed [15:0] set_point;
   logic input_error;
   logic signed [11:0] calc_mv;
   logic signed [11:0] manipulated_value;
   logic heat_out_sel;
   logic cool_out_sel;
   logic run_state;
   logic program_finished;
   logic show_finish;
   logic [3:0] aux1_assign;
   logic [3:0] alarm1_assign;
   logic want_ev = 1'b0;
   logic signed [15:0] want_pv = 16'sh0;
   logic want_err = 1'b0;
   logic signed [11:0] want_calc = 12'sh0;
   logic [31:0] rdat;
   logic [1:0] rresp;
   logic [31:0] r;
   logic [31:0] r2;
   logic signed [11:0] lo;
   logic signed [11:0] hi;
   logic signed [11:0] mn;
   logic signed [11:0] st;
   logic signed [11:0] er;
   int n_fail = 0;
   int n_tests = 0;
   int seed = 23073;
   prog_end_ctrl #(.soak_unit_cycles(10), .blink_cycles(4)) i_prog_end_ctrl (.*);
   op_model i_op_model (.*);
   always #4 clk = ~clk;
   task automatic give_verdict();
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int k = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (k >= 50)
         n_fail++;
      rdat = avs_readdata;
      rresp = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : bus
   task automatic wait_fin(input logic v);
      int k = 0;
      while (program_finished !== v && k < 400) begin
         @(posedge clk);
         k++;
      end
   endtask : wait_fin
   function automatic logic signed [11:0] lim(input logic signed [11:0] v, lo, hi);
      return (v < lo) ? lo : (v > hi) ? hi : v;
   endfunction : lim
   // md: manual, limit enable, stop/error enable, run, error
   function automatic logic signed [11:0] exp_mv(input logic [4:0] md, input logic signed [11:0] c, lo, hi, mn, st, er);
      if (md[0])
         return md[1] ? lim(mn, lo, hi) : mn;
      if (!md[3])
         return md[2] ? st : 12'sh0;
      if (md[2] && md[4])
         return er;
      return lim(c, lo, hi);
   endfunction : exp_mv
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      bus(0, 6'h1c, 0); chk(rdat, 32'h10);
      bus(0, 6'h24, 0); chk(rresp, 2'h2);
      bus(1, 6'h1c, 0);
      bus(1, 6'h00, 32'h1); chk(aux1_assign, 4'h3);
      bus(1, 6'h00, 32'h10); chk(alarm1_assign, 4'h2);
      bus(1, 6'h00, 32'h1);
      bus(1, 6'h00, 32'h0); chk(alarm1_assign, 4'h1);
      bus(1, 6'h08, 0);
      bus(1, 6'h04, 32'd100);
      bus(1, 6'h00, 32'h101); chk(run_state, 1'b1);
      bus(1, 6'h00, 32'h1); chk(run_state, 1'b0);
      bus(1, 6'h04, 32'd2);
      bus(1, 6'h00, 32'h101); wait_fin(1); chk(run_state, 1'b0);
      repeat (40) @(posedge clk);
      chk(program_finished, 1'b1);
      bus(0, 6'h18, 0); chk(rdat[0], 1'b1);
      bus(1, 6'h00, 32'h1); chk({program_finished, show_finish}, 2'b00);
      bus(1, 6'h00, 32'h602);
      bus(1, 6'h00, 32'h102); chk(run_state, 1'b1);
      wait_fin(1); chk(run_state, 1'b1);
      bus(1, 6'h00, 32'h105);
      bus(1, 6'h00, 32'h5);
      want_ev <= 1'b1;
      wait_fin(1);
      bus(1, 6'h00, 32'h105);
      bus(1, 6'h00, 32'h5); chk(program_finished, 1'b1);
      want_ev <= 1'b0;
      repeat (8) @(posedge clk);
      chk(program_finished, 1'b0);
      bus(1, 6'h08, 32'h5);
      want_pv <= 16'sd100;
      bus(1, 6'h00, 32'h101);
      repeat (60) @(posedge clk);
      chk(program_finished, 1'b0);
      bus(1, 6'h00, 32'h301);
      want_pv <= 16'sd3;
      wait_fin(1); chk({program_finished, run_state}, 2'b10);
      bus(1, 6'h00, 32'h1);
      for (int i = 0; i < 24; i++) begin
         r = $random(seed);
         r2 = $random(seed);
         lo = 12'(r[8:0]) - 12'sd50;
         hi = 12'sd500 + 12'(r[17:9]);
         mn = 12'(r[27:18]) - 12'sd50;
         st = 12'(r2[21:12]) - 12'sd50;
         er = 12'(r2[31:22]) - 12'sd50;
         bus(1, 6'h0c, {4'h0, hi, 4'h0, lo});
         bus(1, 6'h10, {4'h0, er, 4'h0, st});
         bus(1, 6'h14, {20'h0, mn});
         bus(1, 6'h00, {21'h0, r[31], 1'b1, 1'b0, r[28], r[29], r[30], 5'h0});
         want_err <= r[30] & r2[11];
         want_calc <= r2[11:0];
         repeat (4) @(posedge clk);
         r = 32'(exp_mv({r2[11], r[31:28]}, r2[11:0], lo, hi, mn, st, er));
         chk(manipulated_value, r);
      end
      bus(1, 6'h10, {20'h0, 12'hf9c});
      bus(0, 6'h10, 0); chk(rdat[11:0], 12'hfce);
      bus(1, 6'h00, 32'h228);
      bus(1, 6'h10, {20'h0, 12'hf9c});
      chk({cool_out_sel, heat_out_sel, manipulated_value}, {2'b10, 12'hf9c});
      give_verdict();
   end
endmodule : tb_top
